//--- cmd_pkg.sv
package cmd_pkg;

	// Prefix bytes placed ahead of the opcode
	localparam logic [7:0] PFX_SECOND_INDEX = 8'h90;
	localparam logic [7:0] PFX_SECOND_INDIRECT = 8'h91;
	localparam logic [7:0] PFX_INDIRECT = 8'h92;
	localparam logic [7:0] PFX_NONE = 8'h00;

	// Opcode columns (upper nibble of the opcode)
	localparam logic [3:0] COL_BIT_REL = 4'h0;
	localparam logic [3:0] COL_BIT = 4'h1;
	localparam logic [3:0] COL_REL = 4'h2;
	localparam logic [3:0] COL_RMW_DIR = 4'h3;
	localparam logic [3:0] COL_RMW_IDX1 = 4'h6;
	localparam logic [3:0] COL_RMW_IDX0 = 4'h7;
	localparam logic [3:0] COL_IMM = 4'hA;
	localparam logic [3:0] COL_DIR_S = 4'hB;
	localparam logic [3:0] COL_DIR_L = 4'hC;
	localparam logic [3:0] COL_IDX_L = 4'hD;
	localparam logic [3:0] COL_IDX_S = 4'hE;
	localparam logic [3:0] COL_IDX_0 = 4'hF;

	// Individual inherent and relative opcodes
	localparam logic [7:0] OP_CALL_REL = 8'hAD;
	localparam logic [7:0] OP_HALT = 8'h8E;
	localparam logic [7:0] OP_WAIT_FOR_INTERRUPT = 8'h8F;
	localparam logic [7:0] OP_BYTE_MULTIPLY = 8'h42;
	localparam logic [5:0] OP_POP_GROUP = 6'h21;
	localparam logic [5:0] OP_PUSH_GROUP = 6'h22;
	localparam logic [1:0] OP_STACK_UNUSED = 2'h3;

	// Address space figures
	localparam logic [7:0] PAGE_ZERO = 8'h00;
	localparam logic [15:0] IDX_SHORT_MAX = 16'h01FE;
	localparam logic [15:0] STACK_RESET = 16'h01FF;
	localparam logic [15:0] ONE_WORD = 16'h0001;
	localparam logic [2:0] OPCODE_LEN = 3'h1;
	localparam int MODE_COUNT = 17;
	localparam int FAMILY_COUNT = 7;

	// The seventeen operand addressing modes
	typedef enum logic [4:0] {
		M_INHERENT, M_IMMEDIATE, M_DIR_SHORT, M_DIR_LONG,
		M_IDX_NONE, M_IDX_SHORT, M_IDX_LONG, M_IND_SHORT, M_IND_LONG,
		M_IND_IDX_SHORT, M_IND_IDX_LONG, M_REL_DIR, M_REL_IND,
		M_BIT_DIR, M_BIT_IND, M_BIT_REL_DIR, M_BIT_REL_IND
	} cmd_mode_t;

	// The seven mode families
	typedef enum logic [2:0] {
		F_INHERENT, F_IMMEDIATE, F_DIRECT, F_INDEXED, F_INDIRECT, F_RELATIVE, F_BIT
	} cmd_family_t;

	// Decoder sequence, Gray along the usual path
	typedef enum logic [2:0] {
		ST_OPCODE = 3'b000,
		ST_OPERAND = 3'b001,
		ST_POINTER = 3'b011,
		ST_ISSUE = 3'b010
	} cmd_state_t;

	// Family of a mode
	function automatic cmd_family_t cmd_family_of(input cmd_mode_t m);
		case (m)
			M_INHERENT: cmd_family_of = F_INHERENT;
			M_IMMEDIATE: cmd_family_of = F_IMMEDIATE;
			M_DIR_SHORT, M_DIR_LONG: cmd_family_of = F_DIRECT;
			M_IDX_NONE, M_IDX_SHORT, M_IDX_LONG: cmd_family_of = F_INDEXED;
			M_REL_DIR, M_REL_IND: cmd_family_of = F_RELATIVE;
			M_BIT_DIR, M_BIT_IND, M_BIT_REL_DIR, M_BIT_REL_IND: cmd_family_of = F_BIT;
			default: cmd_family_of = F_INDIRECT;
		endcase
	endfunction

endpackage

//--- cmd_ea_add.sv
module cmd_ea_add (
	input wire logic [15:0] base,
	input wire logic [7:0] ofs,
	input wire logic sign_ext,
	output logic [15:0] sum
);
	logic [15:0] ofs_ext;

	// Byte offset widened, signed or unsigned
	assign ofs_ext = {{8{sign_ext & ofs[7]}}, ofs};

	// Sum wraps within the 64K space
	assign sum = base + ofs_ext;
endmodule

//--- cmd_decoder.sv
// Operation
// (RULE1) Seventeen addressing modes are decoded, grouped into seven families.
// (RULE2) Long forms take a two-byte address or offset and so reach all 64 Kbyte.
// (RULE3) Short forms take one address byte and land in page zero, 0000h to 00FFh; short indexed forms here reach up to 01FEh.
// (RULE4) Read-modify-write memory opcodes decode only to short addressing forms.
// (RULE5) Inherent instructions are one opcode byte and fetch no operand bytes.
// (RULE6) Indexed without offset adds no byte with the first index, one with the second.
// (RULE7) Relative targets are the next instruction address plus a signed byte offset.
// (RULE8) The wait-for-interrupt opcode raises a wait request when decoded.
// (RULE9) The halt opcode raises a halt request that stops the oscillator.
// (RULE10) Push and pop move the stack pointer with no address byte in the opcode.
// (RULE11) Prefix 90 turns a first-index form into the second-index form.
// (RULE12) Prefix 92 turns direct, bit and first-index indexed forms into indirect ones.
// (RULE13) Prefix 91 turns first-index indirect indexed into second-index indirect indexed.
// (RULE14) Indexed addresses are an unsigned sum of index and offset, up to 1FE for a byte.
// (RULE15) Instruction length counts prefix, opcode and operands; the fetch address follows it.
module cmd_decoder (
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic op_valid,
	input wire logic [7:0] op_byte,
	output logic op_ready,
	output logic [15:0] fetch_addr,
	input wire logic pc_load,
	input wire logic [15:0] pc_load_val,
	input wire logic [7:0] x_index,
	input wire logic [7:0] y_index,
	output logic ptr_rd_req,
	output logic [15:0] ptr_rd_addr,
	input wire logic ptr_rd_valid,
	input wire logic [7:0] ptr_rd_data,
	output logic dec_valid,
	output logic [7:0] dec_opcode,
	output logic [7:0] dec_prefix,
	output cmd_pkg::cmd_mode_t dec_mode,
	output cmd_pkg::cmd_family_t dec_family,
	output logic [2:0] dec_len,
	output logic [15:0] dec_ea,
	output logic [7:0] dec_imm,
	output logic [15:0] dec_target,
	output logic [15:0] dec_next_pc,
	output logic [2:0] dec_bitnum,
	output logic dec_use_y,
	output logic dec_rmw,
	output logic [15:0] dec_stack_addr,
	output logic [15:0] stack_ptr,
	output logic wait_req,
	output logic halt_req
);
	cmd_pkg::cmd_state_t state_r, state_nxt;
	cmd_pkg::cmd_mode_t mode_r, mode_nxt;
	logic [7:0] pfx_r, opcode_r, b1_r, b2_r;
	logic [1:0] nops_r, nops_nxt, argc_r, ptrc_r;
	logic [15:0] ptr_r, ins_pc_r;
	logic take, is_prefix, need_ptr, use_y, got_ptr;
	logic [2:0] len;
	logic [15:0] next_pc, ea_base, ea_sum, target;
	logic [7:0] ea_ofs, rel_ofs;
	logic is_push, is_pop;

	// Mode from column and active prefix
	function automatic cmd_pkg::cmd_mode_t decode_mode(input logic [7:0] op, input logic ind);
		case (op[7:4])
			cmd_pkg::COL_BIT_REL: decode_mode = ind ? cmd_pkg::M_BIT_REL_IND : cmd_pkg::M_BIT_REL_DIR;
			cmd_pkg::COL_BIT: decode_mode = ind ? cmd_pkg::M_BIT_IND : cmd_pkg::M_BIT_DIR;
			cmd_pkg::COL_REL: decode_mode = ind ? cmd_pkg::M_REL_IND : cmd_pkg::M_REL_DIR;
			cmd_pkg::COL_RMW_DIR, cmd_pkg::COL_DIR_S:
				decode_mode = ind ? cmd_pkg::M_IND_SHORT : cmd_pkg::M_DIR_SHORT;
			cmd_pkg::COL_RMW_IDX1, cmd_pkg::COL_IDX_S:
				decode_mode = ind ? cmd_pkg::M_IND_IDX_SHORT : cmd_pkg::M_IDX_SHORT;
			cmd_pkg::COL_RMW_IDX0, cmd_pkg::COL_IDX_0: decode_mode = cmd_pkg::M_IDX_NONE;
			cmd_pkg::COL_DIR_L: decode_mode = ind ? cmd_pkg::M_IND_LONG : cmd_pkg::M_DIR_LONG;
			cmd_pkg::COL_IDX_L: decode_mode = ind ? cmd_pkg::M_IND_IDX_LONG : cmd_pkg::M_IDX_LONG;
			cmd_pkg::COL_IMM: begin
				if (op == cmd_pkg::OP_CALL_REL) begin
					decode_mode = ind ? cmd_pkg::M_REL_IND : cmd_pkg::M_REL_DIR;
				end else begin
					decode_mode = cmd_pkg::M_IMMEDIATE;
				end
			end
			default: decode_mode = cmd_pkg::M_INHERENT;
		endcase
	endfunction

	// Operand bytes following the opcode
	function automatic logic [1:0] operand_bytes(input cmd_pkg::cmd_mode_t m);
		case (m)
			cmd_pkg::M_INHERENT, cmd_pkg::M_IDX_NONE: operand_bytes = 2'h0;
			cmd_pkg::M_DIR_LONG, cmd_pkg::M_IDX_LONG: operand_bytes = 2'h2;
			cmd_pkg::M_BIT_REL_DIR, cmd_pkg::M_BIT_REL_IND: operand_bytes = 2'h2;
			default: operand_bytes = 2'h1;
		endcase
	endfunction

	// Byte handshake and prefix detection
	assign take = op_valid & op_ready;
	assign is_prefix = (pfx_r == cmd_pkg::PFX_NONE) &&
		(op_byte == cmd_pkg::PFX_SECOND_INDEX || op_byte == cmd_pkg::PFX_INDIRECT ||
		op_byte == cmd_pkg::PFX_SECOND_INDIRECT);
	assign mode_nxt = decode_mode(op_byte, pfx_r == cmd_pkg::PFX_INDIRECT ||
		pfx_r == cmd_pkg::PFX_SECOND_INDIRECT); // RULE12 RULE13
	assign nops_nxt = operand_bytes(mode_nxt); // RULE5 RULE2 RULE3
	assign use_y = pfx_r == cmd_pkg::PFX_SECOND_INDEX ||
		pfx_r == cmd_pkg::PFX_SECOND_INDIRECT; // RULE11 RULE13
	assign got_ptr = ptr_rd_req & ptr_rd_valid;

	// Modes whose operand byte addresses a pointer in memory
	always_comb begin
		case (mode_r)
			cmd_pkg::M_IND_SHORT, cmd_pkg::M_IND_LONG, cmd_pkg::M_IND_IDX_SHORT,
			cmd_pkg::M_IND_IDX_LONG, cmd_pkg::M_REL_IND, cmd_pkg::M_BIT_IND,
			cmd_pkg::M_BIT_REL_IND: need_ptr = 1'b1;
			default: need_ptr = 1'b0;
		endcase
	end

	// Sequence: prefix/opcode, operands, pointer, issue
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			cmd_pkg::ST_OPCODE: begin
				if (pc_load) begin
					state_nxt = cmd_pkg::ST_OPCODE;
				end else if (take && !is_prefix) begin
					state_nxt = (nops_nxt == 2'h0) ? cmd_pkg::ST_ISSUE : cmd_pkg::ST_OPERAND;
				end
			end
			cmd_pkg::ST_OPERAND: begin
				if (take && argc_r == nops_r - 2'h1) begin
					state_nxt = need_ptr ? cmd_pkg::ST_POINTER : cmd_pkg::ST_ISSUE;
				end
			end
			cmd_pkg::ST_POINTER: begin
				if (got_ptr && ptrc_r == 2'h1) begin
					state_nxt = cmd_pkg::ST_ISSUE;
				end
			end
			cmd_pkg::ST_ISSUE: state_nxt = cmd_pkg::ST_OPCODE;
			default: state_nxt = cmd_pkg::ST_OPCODE;
		endcase
	end

	// State and handshake flops
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			state_r <= cmd_pkg::ST_OPCODE;
			op_ready <= 1'b0;
			ptr_rd_req <= 1'b0;
		end else begin
			state_r <= state_nxt;
			op_ready <= state_nxt == cmd_pkg::ST_OPCODE || state_nxt == cmd_pkg::ST_OPERAND;
			ptr_rd_req <= state_nxt == cmd_pkg::ST_POINTER;
		end
	end

	// Fetch address loads on a jump in ST_OPCODE, else advances on every byte taken
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			fetch_addr <= 16'h0000;
			ins_pc_r <= 16'h0000;
		end else if (state_r == cmd_pkg::ST_OPCODE && pc_load) begin
			fetch_addr <= pc_load_val;
		end else if (take) begin
			fetch_addr <= fetch_addr + cmd_pkg::ONE_WORD; // RULE15
			if (state_r == cmd_pkg::ST_OPCODE && pfx_r == cmd_pkg::PFX_NONE) begin
				ins_pc_r <= fetch_addr;
			end
		end
	end

	// Prefix, opcode and operand capture
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			pfx_r <= cmd_pkg::PFX_NONE;
			opcode_r <= 8'h00;
			mode_r <= cmd_pkg::M_INHERENT;
			nops_r <= 2'h0;
			argc_r <= 2'h0;
			b1_r <= 8'h00;
			b2_r <= 8'h00;
		end else if (state_r == cmd_pkg::ST_OPCODE) begin
			argc_r <= 2'h0;
			if (pc_load) begin
				pfx_r <= cmd_pkg::PFX_NONE;
			end else if (take && is_prefix) begin
				pfx_r <= op_byte; // RULE11 RULE12 RULE13
			end else if (take) begin
				opcode_r <= op_byte;
				mode_r <= mode_nxt; // RULE1
				nops_r <= nops_nxt;
			end
		end else if (state_r == cmd_pkg::ST_OPERAND && take) begin
			argc_r <= argc_r + 2'h1;
			if (argc_r == 2'h0) begin
				b1_r <= op_byte;
			end else begin
				b2_r <= op_byte;
			end
		end else if (state_r == cmd_pkg::ST_ISSUE) begin
			pfx_r <= cmd_pkg::PFX_NONE;
		end
	end

	// Pointer fetch from page zero, high byte first for a word pointer
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			ptr_r <= 16'h0000;
			ptrc_r <= 2'h0;
			ptr_rd_addr <= 16'h0000;
		end else if (state_r == cmd_pkg::ST_OPERAND) begin
			ptr_rd_addr <= {cmd_pkg::PAGE_ZERO, take && argc_r == 2'h0 ? op_byte : b1_r};
			ptr_r <= 16'h0000;
			ptrc_r <= (mode_r == cmd_pkg::M_IND_LONG || mode_r == cmd_pkg::M_IND_IDX_LONG) ?
				2'h2 : 2'h1;
		end else if (got_ptr) begin
			ptr_r <= {ptr_r[7:0], ptr_rd_data};
			ptrc_r <= ptrc_r - 2'h1;
			ptr_rd_addr <= ptr_rd_addr + cmd_pkg::ONE_WORD;
		end
	end

	// Length and following address
	assign len = cmd_pkg::OPCODE_LEN + {2'h0, pfx_r != cmd_pkg::PFX_NONE} + {1'b0, nops_r}; // RULE15
	assign next_pc = ins_pc_r + {13'h0000, len};

	// Base and offset feeding the address adder
	always_comb begin
		ea_base = {cmd_pkg::PAGE_ZERO, b1_r}; // RULE3
		ea_ofs = 8'h00;
		case (mode_r)
			cmd_pkg::M_DIR_LONG: ea_base = {b1_r, b2_r}; // RULE2
			cmd_pkg::M_IDX_NONE: begin
				ea_base = 16'h0000;
				ea_ofs = use_y ? y_index : x_index;
			end
			cmd_pkg::M_IDX_SHORT: ea_ofs = use_y ? y_index : x_index; // RULE14
			cmd_pkg::M_IDX_LONG: begin
				ea_base = {b1_r, b2_r};
				ea_ofs = use_y ? y_index : x_index;
			end
			cmd_pkg::M_IND_SHORT, cmd_pkg::M_BIT_IND, cmd_pkg::M_BIT_REL_IND:
				ea_base = {cmd_pkg::PAGE_ZERO, ptr_r[7:0]};
			cmd_pkg::M_IND_LONG: ea_base = ptr_r;
			cmd_pkg::M_IND_IDX_SHORT: begin
				ea_base = {cmd_pkg::PAGE_ZERO, ptr_r[7:0]};
				ea_ofs = use_y ? y_index : x_index; // RULE14
			end
			cmd_pkg::M_IND_IDX_LONG: begin
				ea_base = ptr_r;
				ea_ofs = use_y ? y_index : x_index;
			end
			default: ea_base = {cmd_pkg::PAGE_ZERO, b1_r};
		endcase
	end

	// Relative offset source
	always_comb begin
		case (mode_r)
			cmd_pkg::M_REL_IND: rel_ofs = ptr_r[7:0];
			cmd_pkg::M_BIT_REL_DIR, cmd_pkg::M_BIT_REL_IND: rel_ofs = b2_r;
			default: rel_ofs = b1_r;
		endcase
	end

	// Unsigned index sum
	cmd_ea_add u_index_add (
		.base(ea_base),
		.ofs(ea_ofs),
		.sign_ext(1'b0),
		.sum(ea_sum)
	);

	// Signed branch from the following instruction
	cmd_ea_add u_branch_add (
		.base(next_pc),
		.ofs(rel_ofs),
		.sign_ext(1'b1),
		.sum(target)
	); // RULE7

	// Stack opcodes (inherent column 8: pop 84 to 86, push 88 to 8A)
	assign is_pop = mode_r == cmd_pkg::M_INHERENT && opcode_r[7:2] == cmd_pkg::OP_POP_GROUP &&
		opcode_r[1:0] != cmd_pkg::OP_STACK_UNUSED;
	assign is_push = mode_r == cmd_pkg::M_INHERENT && opcode_r[7:2] == cmd_pkg::OP_PUSH_GROUP &&
		opcode_r[1:0] != cmd_pkg::OP_STACK_UNUSED;

	// Decoded instruction issue, one cycle
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			dec_valid <= 1'b0;
			dec_opcode <= 8'h00;
			dec_prefix <= cmd_pkg::PFX_NONE;
			dec_mode <= cmd_pkg::M_INHERENT;
			dec_family <= cmd_pkg::F_INHERENT;
			dec_len <= 3'h0;
			dec_ea <= 16'h0000;
			dec_imm <= 8'h00;
			dec_target <= 16'h0000;
			dec_next_pc <= 16'h0000;
			dec_bitnum <= 3'h0;
			dec_use_y <= 1'b0;
			dec_rmw <= 1'b0;
		end else begin
			dec_valid <= state_r == cmd_pkg::ST_ISSUE;
			if (state_r == cmd_pkg::ST_ISSUE) begin
				dec_opcode <= opcode_r;
				dec_prefix <= pfx_r;
				dec_mode <= mode_r;
				dec_family <= cmd_pkg::cmd_family_of(mode_r); // RULE1
				dec_len <= len; // RULE15 RULE6
				dec_ea <= ea_sum;
				dec_imm <= b1_r;
				dec_target <= target; // RULE7
				dec_next_pc <= next_pc;
				dec_bitnum <= opcode_r[3:1];
				dec_use_y <= use_y;
				dec_rmw <= opcode_r[7:4] == cmd_pkg::COL_BIT_REL ||
					opcode_r[7:4] == cmd_pkg::COL_BIT || opcode_r[7:4] == cmd_pkg::COL_RMW_DIR ||
					opcode_r[7:4] == cmd_pkg::COL_RMW_IDX1 ||
					opcode_r[7:4] == cmd_pkg::COL_RMW_IDX0; // RULE4
			end
		end
	end

	// Power requests and stack pointer
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			wait_req <= 1'b0;
			halt_req <= 1'b0;
			stack_ptr <= cmd_pkg::STACK_RESET;
			dec_stack_addr <= cmd_pkg::STACK_RESET;
		end else begin
			wait_req <= state_r == cmd_pkg::ST_ISSUE && mode_r == cmd_pkg::M_INHERENT &&
				opcode_r == cmd_pkg::OP_WAIT_FOR_INTERRUPT; // RULE8
			halt_req <= state_r == cmd_pkg::ST_ISSUE && mode_r == cmd_pkg::M_INHERENT &&
				opcode_r == cmd_pkg::OP_HALT; // RULE9
			if (state_r == cmd_pkg::ST_ISSUE && is_push) begin
				dec_stack_addr <= stack_ptr;
				stack_ptr <= stack_ptr - cmd_pkg::ONE_WORD; // RULE10
			end else if (state_r == cmd_pkg::ST_ISSUE && is_pop) begin
				dec_stack_addr <= stack_ptr + cmd_pkg::ONE_WORD;
				stack_ptr <= stack_ptr + cmd_pkg::ONE_WORD; // RULE10
			end
		end
	end

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!nrst);

	inh_len_a: // RULE5
	assert property (dec_valid && dec_mode == cmd_pkg::M_INHERENT
		|-> dec_len == ((dec_prefix == cmd_pkg::PFX_NONE) ? 3'h1 : 3'h2))
		else $error("inherent length wrong");
	idx0_len_a: // RULE6
	assert property (dec_valid && dec_mode == cmd_pkg::M_IDX_NONE
		|-> dec_len == ((dec_use_y || dec_prefix != cmd_pkg::PFX_NONE) ? 3'h2 : 3'h1) &&
		dec_ea[15:8] == 8'h00)
		else $error("no-offset indexed length wrong");
	long_len_a: // RULE2
	assert property (dec_valid && (dec_mode == cmd_pkg::M_DIR_LONG || dec_mode == cmd_pkg::M_IDX_LONG)
		|-> dec_len == 3'h3 + {2'h0, dec_prefix != cmd_pkg::PFX_NONE})
		else $error("long form length wrong");
	short_page_a: // RULE3
	assert property (dec_valid && (dec_mode == cmd_pkg::M_DIR_SHORT || dec_mode == cmd_pkg::M_BIT_DIR)
		|-> dec_ea[15:8] == 8'h00)
		else $error("short address left page zero");
	rmw_short_a: // RULE4
	assert property (dec_valid && dec_rmw |-> !(dec_mode inside {cmd_pkg::M_DIR_LONG,
		cmd_pkg::M_IDX_LONG, cmd_pkg::M_IND_LONG, cmd_pkg::M_IND_IDX_LONG}))
		else $error("read-modify-write in long form");
	rel_range_a: // RULE7
	assert property (dec_valid && dec_mode == cmd_pkg::M_REL_DIR
		|-> (dec_target - dec_next_pc) <= 16'h007F || (dec_target - dec_next_pc) >= 16'hFF80)
		else $error("relative target out of range");
	wait_req_a: // RULE8
	assert property (dec_valid && dec_opcode == cmd_pkg::OP_WAIT_FOR_INTERRUPT &&
		dec_mode == cmd_pkg::M_INHERENT |-> wait_req ##1 !wait_req)
		else $error("wait request missing");
	halt_req_a: // RULE9
	assert property ($rose(halt_req) |-> dec_valid && dec_opcode == cmd_pkg::OP_HALT)
		else $error("halt request without halt opcode");
	push_sp_a: // RULE10
	assert property (dec_valid && dec_mode == cmd_pkg::M_INHERENT &&
		dec_opcode[7:2] == cmd_pkg::OP_PUSH_GROUP && dec_opcode[1:0] != 2'h3
		|-> stack_ptr == dec_stack_addr - 16'h0001)
		else $error("push did not lower stack pointer");
	y_prefix_a: // RULE11
	assert property (dec_valid && dec_use_y |-> dec_prefix == cmd_pkg::PFX_SECOND_INDEX ||
		dec_prefix == cmd_pkg::PFX_SECOND_INDIRECT)
		else $error("second index without prefix");
	ind_prefix_a: // RULE12
	assert property (dec_valid && dec_family == cmd_pkg::F_INDIRECT
		|-> dec_prefix == cmd_pkg::PFX_INDIRECT || dec_prefix == cmd_pkg::PFX_SECOND_INDIRECT)
		else $error("indirect form without prefix");
	idx_max_a: // RULE14
	assert property (dec_valid && dec_mode == cmd_pkg::M_IDX_SHORT |-> dec_ea <= 16'h01FE)
		else $error("short indexed beyond 1FE");
	next_pc_a: // RULE15
	assert property (dec_valid |-> dec_next_pc == fetch_addr && $past(ptr_rd_req, 1) == 1'b0)
		else $error("fetch address does not follow instruction");
endmodule

//--- cmd_mem_model.sv
module cmd_mem_model (
	input wire logic ref_clk,
	input wire logic en,
	input wire logic [3:0] ptr_wait,
	input wire logic [15:0] fetch_addr,
	output logic op_valid,
	output logic [7:0] op_byte,
	input wire logic ptr_rd_req,
	input wire logic [15:0] ptr_rd_addr,
	output logic ptr_rd_valid,
	output logic [7:0] ptr_rd_data
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [7:0] prog [0:255];
	logic [7:0] dmem [0:255];
	logic taken;
	int cnt;

	// Quiet outputs at time zero
	initial begin
		op_valid = 1'b0;
		op_byte = 8'h00;
		ptr_rd_valid = 1'b0;
		ptr_rd_data = 8'h00;
		cnt = 0;
	end

	// Program byte at fetch_addr, held until taken; garbage while stopped
	always @(posedge ref_clk) begin
		#1;
		op_valid = en;
		op_byte = en ? prog[fetch_addr[7:0]] : ~op_byte;
	end

	// Pointer reads answered after ptr_wait idle cycles, one byte per request
	always @(posedge ref_clk) begin
		taken = ptr_rd_req && ptr_rd_valid;
		#1;
		if (taken || !ptr_rd_req) begin
			ptr_rd_valid = 1'b0;
			cnt = 0;
			ptr_rd_data = ~ptr_rd_data; // Released data does not linger
		end else if (cnt >= ptr_wait) begin
			ptr_rd_valid = 1'b1;
			ptr_rd_data = dmem[ptr_rd_addr[7:0]];
		end else begin
			cnt = cnt + 1;
		end
	end
endmodule

//--- test_cpu_addressing_mode_decoder.sv
module test_cpu_addressing_mode_decoder;
	timeunit 1ns;
	timeprecision 100ps;
	localparam logic [15:0] NO_EA = 16'hFFFF;
	logic ref_clk = 1'b0;
	logic nrst, en, pc_load, op_valid, op_ready, ptr_rd_req, ptr_rd_valid;
	logic [3:0] ptr_wait;
	logic [7:0] op_byte, x_index, y_index, ptr_rd_data, dec_opcode, dec_prefix, dec_imm;
	logic [15:0] fetch_addr, pc_load_val, ptr_rd_addr, dec_ea, dec_target, dec_next_pc;
	logic [15:0] dec_stack_addr, stack_ptr, exp_pc;
	logic [2:0] dec_len, dec_bitnum;
	logic dec_valid, dec_use_y, dec_rmw, wait_req, halt_req;
	cmd_pkg::cmd_mode_t dec_mode;
	cmd_pkg::cmd_family_t dec_family;
	int n_mismatch = 0;
	int total_checks = 0;
	logic [7:0] code [$] = '{8'h9D, 8'hA6, 8'h55, 8'hB6, 8'h10, 8'hC6, 8'h12, 8'h34, 8'hF6,
		8'h90, 8'hF6, 8'hE6, 8'hFF, 8'hD6, 8'h12, 8'h00, 8'h92, 8'hB6, 8'h20, 8'h92, 8'hC6,
		8'h21, 8'h92, 8'hE6, 8'h20, 8'h91, 8'hE6, 8'h20, 8'h20, 8'hFE, 8'h27, 8'h7F, 8'h1A,
		8'h30, 8'h0E, 8'h30, 8'h80, 8'h3C, 8'h40, 8'h8F, 8'h8E, 8'h88, 8'h84, 8'h9D, 8'hA6};
	// Program that follows the jump target, from 0081 on
	logic [7:0] code_far [$] = '{8'h92, 8'h27, 8'h22, 8'h92, 8'hD6, 8'h21, 8'h92, 8'h1A,
		8'h20, 8'h92, 8'h0E, 8'h20, 8'hF0, 8'hAD, 8'h10};

	// Clock at 250 MHz
	always #2 ref_clk = ~ref_clk;

	cmd_mem_model u_mem (.ref_clk(ref_clk), .en(en), .ptr_wait(ptr_wait),
		.fetch_addr(fetch_addr), .op_valid(op_valid), .op_byte(op_byte),
		.ptr_rd_req(ptr_rd_req), .ptr_rd_addr(ptr_rd_addr), .ptr_rd_valid(ptr_rd_valid),
		.ptr_rd_data(ptr_rd_data));

	cmd_decoder u_dut (.ref_clk(ref_clk), .nrst(nrst), .op_valid(op_valid), .op_byte(op_byte),
		.op_ready(op_ready), .fetch_addr(fetch_addr), .pc_load(pc_load),
		.pc_load_val(pc_load_val), .x_index(x_index), .y_index(y_index),
		.ptr_rd_req(ptr_rd_req), .ptr_rd_addr(ptr_rd_addr), .ptr_rd_valid(ptr_rd_valid),
		.ptr_rd_data(ptr_rd_data), .dec_valid(dec_valid), .dec_opcode(dec_opcode),
		.dec_prefix(dec_prefix), .dec_mode(dec_mode), .dec_family(dec_family),
		.dec_len(dec_len), .dec_ea(dec_ea), .dec_imm(dec_imm), .dec_target(dec_target),
		.dec_next_pc(dec_next_pc), .dec_bitnum(dec_bitnum), .dec_use_y(dec_use_y),
		.dec_rmw(dec_rmw), .dec_stack_addr(dec_stack_addr), .stack_ptr(stack_ptr),
		.wait_req(wait_req), .halt_req(halt_req));

	// Compare and count
	task check(input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// Verdict and end of run
	task finish_test;
		$display("mismatches %0d of %0d checks", n_mismatch, total_checks);
		if (n_mismatch == 0 && total_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// Next decode pulse, bounded
	task wait_dec;
		int i;
		i = 0;
		do begin
			@(posedge ref_clk);
			#1;
			i++;
		end while (dec_valid !== 1'b1 && i < 40);
		if (dec_valid !== 1'b1) begin
			n_mismatch++;
			finish_test();
		end
	endtask

	// Common fields of one decoded instruction
	task expect_dec(input logic [7:0] pfx, input cmd_pkg::cmd_mode_t mode,
		input cmd_pkg::cmd_family_t fam, input logic [2:0] len, input logic [15:0] ea);
		wait_dec();
		check(dec_prefix, pfx);
		check(dec_mode, mode);
		check(dec_family, fam);
		check(dec_len, len);
		if (ea !== NO_EA)
			check(dec_ea, ea);
		check(dec_next_pc, exp_pc + len);
		exp_pc = exp_pc + len;
		check(fetch_addr, exp_pc);
		check(op_ready, 1'b1);
	endtask

	task t_reset;
		check(stack_ptr, 16'h01FF);
		check(dec_stack_addr, 16'h01FF);
		check(op_ready, 1'b0);
		check(dec_valid, 1'b0);
	endtask

	task t_inherent_imm;
		expect_dec(8'h00, cmd_pkg::M_INHERENT, cmd_pkg::F_INHERENT, 3'h1, NO_EA);
		expect_dec(8'h00, cmd_pkg::M_IMMEDIATE, cmd_pkg::F_IMMEDIATE, 3'h2, NO_EA);
		check(dec_imm, 8'h55);
	endtask

	task t_direct;
		expect_dec(8'h00, cmd_pkg::M_DIR_SHORT, cmd_pkg::F_DIRECT, 3'h2, 16'h0010);
		expect_dec(8'h00, cmd_pkg::M_DIR_LONG, cmd_pkg::F_DIRECT, 3'h3, 16'h1234);
		check(dec_rmw, 1'b0);
	endtask

	task t_indexed;
		expect_dec(8'h00, cmd_pkg::M_IDX_NONE, cmd_pkg::F_INDEXED, 3'h1, 16'h00FF);
		check(dec_use_y, 1'b0);
		expect_dec(8'h90, cmd_pkg::M_IDX_NONE, cmd_pkg::F_INDEXED, 3'h2, 16'h0033);
		check(dec_use_y, 1'b1);
		expect_dec(8'h00, cmd_pkg::M_IDX_SHORT, cmd_pkg::F_INDEXED, 3'h2, 16'h01FE);
		expect_dec(8'h00, cmd_pkg::M_IDX_LONG, cmd_pkg::F_INDEXED, 3'h3, 16'h12FF);
	endtask

	// Pointer fetches, prompt and slow
	task t_indirect;
		expect_dec(8'h92, cmd_pkg::M_IND_SHORT, cmd_pkg::F_INDIRECT, 3'h3, 16'h0044);
		ptr_wait = 4'h3;
		expect_dec(8'h92, cmd_pkg::M_IND_LONG, cmd_pkg::F_INDIRECT, 3'h3, 16'hABCD);
		expect_dec(8'h92, cmd_pkg::M_IND_IDX_SHORT, cmd_pkg::F_INDIRECT, 3'h3, 16'h0143);
		ptr_wait = 4'h0;
		expect_dec(8'h91, cmd_pkg::M_IND_IDX_SHORT, cmd_pkg::F_INDIRECT, 3'h3, 16'h0077);
		check(dec_use_y, 1'b1);
	endtask

	task t_relative;
		expect_dec(8'h00, cmd_pkg::M_REL_DIR, cmd_pkg::F_RELATIVE, 3'h2, NO_EA);
		check(dec_target, 16'h001C);
		expect_dec(8'h00, cmd_pkg::M_REL_DIR, cmd_pkg::F_RELATIVE, 3'h2, NO_EA);
		check(dec_target, 16'h009F);
	endtask

	task t_bit_rmw;
		expect_dec(8'h00, cmd_pkg::M_BIT_DIR, cmd_pkg::F_BIT, 3'h2, 16'h0030);
		check(dec_bitnum, 3'h5);
		check(dec_rmw, 1'b1);
		expect_dec(8'h00, cmd_pkg::M_BIT_REL_DIR, cmd_pkg::F_BIT, 3'h3, 16'h0030);
		check(dec_bitnum, 3'h7);
		check(dec_target, 16'hFFA5);
		expect_dec(8'h00, cmd_pkg::M_DIR_SHORT, cmd_pkg::F_DIRECT, 3'h2, 16'h0040);
		check(dec_rmw, 1'b1);
	endtask

	task t_power_stack;
		expect_dec(8'h00, cmd_pkg::M_INHERENT, cmd_pkg::F_INHERENT, 3'h1, NO_EA);
		check({wait_req, halt_req}, 2'h2);
		check(dec_opcode, 8'h8F);
		expect_dec(8'h00, cmd_pkg::M_INHERENT, cmd_pkg::F_INHERENT, 3'h1, NO_EA);
		check({wait_req, halt_req}, 2'h1);
		check(dec_opcode, 8'h8E);
		expect_dec(8'h00, cmd_pkg::M_INHERENT, cmd_pkg::F_INHERENT, 3'h1, NO_EA);
		check(dec_stack_addr, 16'h01FF);
		check(stack_ptr, 16'h01FE);
		expect_dec(8'h00, cmd_pkg::M_INHERENT, cmd_pkg::F_INHERENT, 3'h1, NO_EA);
		check(stack_ptr, 16'h01FF);
		check(dec_stack_addr, 16'h01FF);
	endtask

	// Jump while the next opcode is offered; that byte must be dropped
	task t_jump;
		expect_dec(8'h00, cmd_pkg::M_INHERENT, cmd_pkg::F_INHERENT, 3'h1, NO_EA);
		pc_load = 1'b1;
		pc_load_val = 16'h0080;
		@(posedge ref_clk);
		#1;
		pc_load = 1'b0;
		exp_pc = 16'h0080;
		expect_dec(8'h00, cmd_pkg::M_INHERENT, cmd_pkg::F_INHERENT, 3'h1, NO_EA);
	endtask

	// Indirect relative, word pointer indexed, bit indirect forms and relative call
	task t_prefix_forms;
		expect_dec(8'h92, cmd_pkg::M_REL_IND, cmd_pkg::F_RELATIVE, 3'h3, NO_EA);
		check(dec_target, 16'h0051);
		expect_dec(8'h92, cmd_pkg::M_IND_IDX_LONG, cmd_pkg::F_INDIRECT, 3'h3, 16'hACCC);
		expect_dec(8'h92, cmd_pkg::M_BIT_IND, cmd_pkg::F_BIT, 3'h3, 16'h0044);
		check(dec_bitnum, 3'h5);
		check(dec_rmw, 1'b1);
		expect_dec(8'h92, cmd_pkg::M_BIT_REL_IND, cmd_pkg::F_BIT, 3'h4, 16'h0044);
		check(dec_target, 16'h007E);
		expect_dec(8'h00, cmd_pkg::M_REL_DIR, cmd_pkg::F_RELATIVE, 3'h2, NO_EA);
		check(dec_opcode, 8'hAD);
		check(dec_target, 16'h00A0);
	endtask

	// Main sequence
	initial begin
		nrst = 1'b0;
		en = 1'b0;
		ptr_wait = 4'h0;
		pc_load = 1'b0;
		pc_load_val = 16'h0000;
		x_index = 8'hFF;
		y_index = 8'h33;
		exp_pc = 16'h0000;
		for (int i = 0; i < 256; i++) begin
			u_mem.prog[i] = 8'h9D;
			u_mem.dmem[i] = 8'h00;
		end
		foreach (code[i])
			u_mem.prog[i] = code[i];
		foreach (code_far[i])
			u_mem.prog[8'h81 + i] = code_far[i];
		u_mem.dmem[8'h20] = 8'h44;
		u_mem.dmem[8'h21] = 8'hAB;
		u_mem.dmem[8'h22] = 8'hCD;
		repeat (16) @(posedge ref_clk);
		#1;
		t_reset();
		nrst = 1'b1;
		en = 1'b1;
		t_inherent_imm();
		t_direct();
		t_indexed();
		t_indirect();
		t_relative();
		t_bit_rmw();
		t_power_stack();
		t_jump();
		t_prefix_forms();
		finish_test();
	end
endmodule
